// *** rtl/tcu_pkg.sv ***
package tcu_pkg;
    localparam logic [7:0] TCU_BOTTOM = 8'h00;
    localparam logic [7:0] TCU_MAX = 8'hff;
    localparam logic [7:0] TCU_COUNT_RST = 8'h00;
    localparam logic [7:0] TCU_CMP_RST = 8'h00;
    localparam logic [2:0] TCU_CS_STOP = 3'h0;
    localparam logic [2:0] TCU_WGM_NORMAL = 3'h0;
    localparam logic [2:0] TCU_WGM_PC_FF = 3'h1;
    localparam logic [2:0] TCU_WGM_CTC = 3'h2;
    localparam logic [2:0] TCU_WGM_FAST_FF = 3'h3;
    localparam logic [2:0] TCU_WGM_PC_A = 3'h5;
    localparam logic [2:0] TCU_WGM_FAST_A = 3'h7;
    localparam logic [1:0] TCU_COM_NONE = 2'h0;
    localparam logic [1:0] TCU_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TCU_COM_CLEAR = 2'h2;
    localparam logic [1:0] TCU_COM_SET = 2'h3;
    localparam int TCU_PRE_W = 10;
    localparam logic [9:0] TCU_PRE_RST = 10'h000;

    typedef enum logic [1:0] {
        TCU_SEQ_NORMAL,
        TCU_SEQ_CTC,
        TCU_SEQ_FAST,
        TCU_SEQ_PHASE
    } tcu_seq_t;
endpackage

// *** rtl/tcu_tick_gen.sv ***
// picks the timer tick from the free-running prescaler or the crystal side
module tcu_tick_gen
    import tcu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n,
    input wire logic enable_i,
    input wire logic [2:0] clock_select_field_i,
    input wire logic async_clock_select_i,
    input wire logic crystal_pin_in_i,
    output logic timer_tick_o
);
    import tcu_pkg::*;

    typedef struct packed {
        logic [9:0] pre;
        logic xtal_s1;
        logic xtal_s2;
        logic xtal_d;
    } tcu_tick_state_t;

    tcu_tick_state_t st;
    tcu_tick_state_t next_st;
    logic src_tick;
    logic xtal_rise;

    always_comb begin
        next_st = st;
        next_st.pre = enable_i ? 10'(st.pre + 10'h001) : TCU_PRE_RST;
        next_st.xtal_s1 = crystal_pin_in_i;
        next_st.xtal_s2 = st.xtal_s1;
        next_st.xtal_d = st.xtal_s2;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // crystal edge is sampled, so it must run well below clk_i / 2
    assign xtal_rise = st.xtal_s2 & ~st.xtal_d;

    always_comb begin
        case (clock_select_field_i)
            3'h1: src_tick = 1'b1;
            3'h2: src_tick = (st.pre[2:0] == 3'h7);
            3'h3: src_tick = (st.pre[4:0] == 5'h1f);
            3'h4: src_tick = (st.pre[5:0] == 6'h3f);
            3'h5: src_tick = (st.pre[6:0] == 7'h7f);
            3'h6: src_tick = (st.pre[7:0] == 8'hff);
            3'h7: src_tick = (st.pre == 10'h3ff);
            default: src_tick = 1'b0;
        endcase
    end

    // async source: one tick per crystal rise, only with select 1; other selects give no tick
    assign timer_tick_o = enable_i && (clock_select_field_i != TCU_CS_STOP) &&
        (async_clock_select_i ? (xtal_rise && clock_select_field_i == 3'h1) : src_tick);
endmodule // tcu_tick_gen

// *** rtl/tcu_timer.sv ***
// What this block does
// - counter and both compare values are 8-bit registers.
// - whole module but flag clears idle until the power reduce bit is zero.
// - every request shows in the flag register, each masked separately.
// - clock select zero stops all ticks and the counter.
// - tick from I/O clock, or crystal pin when async select is set.
// - each tick clears, counts up or down; CPU reaches counter anytime the power reduce bit is zero.
// - CPU counter write beats any clear or count that cycle.
// - three-bit waveform mode split across both control registers.
// - BOTTOM 0x00, MAX 0xFF, TOP is MAX or compare A.
// - equality sets compare flag at the following timer tick.
// - compare interrupt when flag set and mask bit set.
// - compare flag clears on service or written one.
// - waveform logic gets match, modes, MAX and BOTTOM.
// - overflow flag set where the mode says; usable as interrupt.
// - PWM modes double-buffer compare values, updated at TOP or BOTTOM.
// - CPU compare writes go to buffer when buffering, else direct.
// - force strobe in non-PWM updates output only, no flag, no reload.
// - counter write blocks compare matches on next tick, even stopped.
// - output bits keep value across waveform mode changes.
// - output mode bits are not buffered, act immediately.
// - mode 0 normal, mode 2 CTC, modes 3 and 7 fast PWM.
// - normal mode overflow flag set on the tick the counter wraps.
module tcu_timer
    import tcu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic power_reduce_bit_i,
    input wire logic async_clock_select_i,
    input wire logic crystal_pin_in_i,
    input wire logic [2:0] clock_select_field_i,
    input wire logic [1:0] waveform_mode_low_i,
    input wire logic waveform_mode_high_i,
    input wire logic [1:0] compare_output_mode_a_i,
    input wire logic [1:0] compare_output_mode_b_i,
    input wire logic count_wr_i,
    input wire logic [7:0] count_wdata_i,
    input wire logic compare_a_wr_i,
    input wire logic compare_b_wr_i,
    input wire logic [7:0] compare_wdata_i,
    input wire logic force_compare_strobe_a_i,
    input wire logic force_compare_strobe_b_i,
    input wire logic flag_wr_i,
    input wire logic [2:0] flag_wdata_i,
    input wire logic [2:0] timer_mask_reg_i,
    input wire logic [2:0] irq_serviced_i,
    output logic [7:0] count_value_o,
    output logic [7:0] compare_value_a_o,
    output logic [7:0] compare_value_b_o,
    output logic [2:0] timer_flag_reg_o,
    output logic [2:0] irq_o,
    output logic compare_out_a_o,
    output logic compare_out_b_o,
    output logic crystal_pin_out_o,
    output logic timer_tick_o
);
    import tcu_pkg::*;

    // flag bit order: 0 overflow, 1 compare a, 2 compare b

    typedef struct packed {
        logic rs1;
        logic rs2;
    } tcu_rst_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] buf_a;
        logic [7:0] buf_b;
        logic [2:0] flags;
        logic out_a;
        logic out_b;
        logic block;
        logic down;
    } tcu_state_t;

    tcu_rst_state_t rs;
    tcu_rst_state_t next_rs;
    tcu_state_t st;
    tcu_state_t next_st;
    logic rst_n;
    logic enable;
    logic tick;
    logic [2:0] wgm;
    tcu_seq_t seq;
    logic pwm;
    logic [7:0] top;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic match_a;
    logic match_b;
    logic [2:0] set_flags;

    function automatic tcu_seq_t decode_seq(input logic [2:0] m);
        case (m)
            TCU_WGM_NORMAL: decode_seq = TCU_SEQ_NORMAL;
            TCU_WGM_CTC: decode_seq = TCU_SEQ_CTC;
            TCU_WGM_FAST_FF, TCU_WGM_FAST_A: decode_seq = TCU_SEQ_FAST;
            TCU_WGM_PC_FF, TCU_WGM_PC_A: decode_seq = TCU_SEQ_PHASE;
            default: decode_seq = TCU_SEQ_NORMAL;
        endcase
    endfunction

    // output action on a match; pwm modes flip sense at the restart point
    function automatic logic cmp_action(input logic [1:0] com, input logic cur,
                                        input logic pwm_m, input logic up);
        case (com)
            TCU_COM_TOGGLE: cmp_action = pwm_m ? cur : ~cur;
            TCU_COM_CLEAR: cmp_action = pwm_m ? ~up : 1'b0;
            TCU_COM_SET: cmp_action = pwm_m ? up : 1'b1;
            default: cmp_action = cur;
        endcase
    endfunction

    always_comb begin
        next_rs.rs1 = 1'b1;
        next_rs.rs2 = rs.rs1;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rs <= '0;
        end else begin
            rs <= next_rs;
        end
    end

    assign rst_n = rs.rs2;
    assign enable = ~power_reduce_bit_i;

    tcu_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_n(rst_n),
        .enable_i(enable),
        .clock_select_field_i(clock_select_field_i),
        .async_clock_select_i(async_clock_select_i),
        .crystal_pin_in_i(crystal_pin_in_i),
        .timer_tick_o(tick)
    );

    assign wgm = {waveform_mode_high_i, waveform_mode_low_i};
    assign seq = decode_seq(wgm);
    assign pwm = (seq == TCU_SEQ_FAST) || (seq == TCU_SEQ_PHASE);
    assign top = wgm[2] ? st.cmp_a : TCU_MAX;
    assign at_top = (st.count == top);
    assign at_bottom = (st.count == TCU_BOTTOM);
    assign at_max = (st.count == TCU_MAX);
    // matches are seen once per tick and suppressed right after a counter write
    assign match_a = tick && !st.block && (st.count == st.cmp_a);
    assign match_b = tick && !st.block && (st.count == st.cmp_b);

    always_comb begin
        next_st = st;
        set_flags = 3'h0;
        if (tick) begin
            next_st.block = 1'b0;
        end
        // counter sequence
        if (tick) begin
            case (seq)
                TCU_SEQ_NORMAL: begin
                    next_st.count = 8'(st.count + 8'h01);
                    next_st.down = 1'b0;
                    set_flags[0] = at_max;
                end
                TCU_SEQ_CTC: begin
                    next_st.count = (st.count == st.cmp_a) ? TCU_BOTTOM
                                                           : 8'(st.count + 8'h01);
                    next_st.down = 1'b0;
                    set_flags[0] = at_max;
                end
                TCU_SEQ_FAST: begin
                    next_st.count = at_top ? TCU_BOTTOM : 8'(st.count + 8'h01);
                    next_st.down = 1'b0;
                    set_flags[0] = at_top;
                end
                TCU_SEQ_PHASE: begin
                    if (st.down) begin
                        next_st.count = 8'(st.count - 8'h01);
                        next_st.down = (st.count != 8'h01);
                    end else begin
                        next_st.count = 8'(st.count + 8'h01);
                        next_st.down = (8'(st.count + 8'h01) == top);
                    end
                    set_flags[0] = at_bottom;
                end
                default: begin
                    next_st.count = st.count;
                end
            endcase
        end
        if (count_wr_i && enable) begin
            next_st.count = count_wdata_i;
            next_st.block = 1'b1;
        end
        // buffer transfer at the restart point of the pwm sequence
        if (pwm && tick && ((seq == TCU_SEQ_FAST) ? at_top : at_bottom)) begin
            next_st.cmp_a = st.buf_a;
            next_st.cmp_b = st.buf_b;
        end
        if (compare_a_wr_i && enable) begin
            next_st.buf_a = compare_wdata_i;
            if (!pwm) begin
                next_st.cmp_a = compare_wdata_i;
            end
        end
        if (compare_b_wr_i && enable) begin
            next_st.buf_b = compare_wdata_i;
            if (!pwm) begin
                next_st.cmp_b = compare_wdata_i;
            end
        end
        // in unbuffered modes the buffer shadows the live value when idle
        if (!pwm && !compare_a_wr_i) begin
            next_st.buf_a = next_st.cmp_a;
        end
        if (!pwm && !compare_b_wr_i) begin
            next_st.buf_b = next_st.cmp_b;
        end
        set_flags[1] = match_a;
        set_flags[2] = match_b;
        // output bits: compare output mode read live, never buffered
        if (match_a) begin
            next_st.out_a = cmp_action(compare_output_mode_a_i, st.out_a, pwm, ~st.down);
        end
        if (match_b) begin
            next_st.out_b = cmp_action(compare_output_mode_b_i, st.out_b, pwm, ~st.down);
        end
        if (pwm && tick && seq == TCU_SEQ_FAST && at_top) begin
            if (compare_output_mode_a_i == TCU_COM_CLEAR) next_st.out_a = 1'b1;
            if (compare_output_mode_a_i == TCU_COM_SET) next_st.out_a = 1'b0;
            if (compare_output_mode_b_i == TCU_COM_CLEAR) next_st.out_b = 1'b1;
            if (compare_output_mode_b_i == TCU_COM_SET) next_st.out_b = 1'b0;
        end
        // forced match touches the output only
        if (!pwm && enable && force_compare_strobe_a_i) begin
            next_st.out_a = cmp_action(compare_output_mode_a_i, st.out_a, 1'b0, 1'b0);
        end
        if (!pwm && enable && force_compare_strobe_b_i) begin
            next_st.out_b = cmp_action(compare_output_mode_b_i, st.out_b, 1'b0, 1'b0);
        end
        // set wins over a clear in the same cycle; zeros written are ignored
        next_st.flags = st.flags & ~irq_serviced_i;
        if (flag_wr_i) begin
            next_st.flags = next_st.flags & ~flag_wdata_i;
        end
        next_st.flags = next_st.flags | set_flags;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count_value_o = st.count;
    assign compare_value_a_o = pwm ? st.buf_a : st.cmp_a;
    assign compare_value_b_o = pwm ? st.buf_b : st.cmp_b;
    assign timer_flag_reg_o = st.flags;
    assign irq_o = st.flags & timer_mask_reg_i;
    assign compare_out_a_o = st.out_a;
    assign compare_out_b_o = st.out_b;
    // no on-chip oscillator; pin_out just drives the inverse of crystal_pin_in_i
    assign crystal_pin_out_o = ~crystal_pin_in_i;
    assign timer_tick_o = tick;

    a_stop_no_tick: assert property (@(posedge clk_i) disable iff (!rst_n)
        (clock_select_field_i == TCU_CS_STOP || power_reduce_bit_i) |-> !tick)
        else $error("tick while stopped");
    a_off_no_tick: assert property (@(posedge clk_i) disable iff (!rst_n)
        power_reduce_bit_i |-> !tick)
        else $error("tick while powered down");
    a_write_wins: assert property (@(posedge clk_i) disable iff (!rst_n)
        (count_wr_i && enable) |=> (count_value_o == $past(count_wdata_i)))
        else $error("counter write lost");
    a_hold_no_tick: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!tick && !count_wr_i) |=> $stable(count_value_o))
        else $error("counter moved without tick");
    a_match_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
        match_a |=> timer_flag_reg_o[1])
        else $error("compare a flag missed");
    a_block_match: assert property (@(posedge clk_i) disable iff (!rst_n)
        (count_wr_i && enable) ##1 (tick && !count_wr_i) |-> !match_a && !match_b)
        else $error("match after counter write");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_o[1] == (timer_flag_reg_o[1] && timer_mask_reg_i[1]))
        else $error("irq gating wrong");
    a_force_noflag: assert property (@(posedge clk_i) disable iff (!rst_n)
        (force_compare_strobe_a_i && !match_a && !flag_wr_i && !timer_flag_reg_o[1])
        |=> !timer_flag_reg_o[1])
        else $error("force set a flag");
    a_normal_ovf: assert property (@(posedge clk_i) disable iff (!rst_n)
        (seq == TCU_SEQ_NORMAL && tick && at_max && !count_wr_i)
        |=> timer_flag_reg_o[0] && count_value_o == TCU_BOTTOM)
        else $error("overflow not set on wrap");
    a_flag_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
        (flag_wr_i && flag_wdata_i == 3'h0 && irq_serviced_i == 3'h0) |=>
        ((timer_flag_reg_o & $past(timer_flag_reg_o)) == $past(timer_flag_reg_o)))
        else $error("zero write cleared flag");
    a_match_flag_b: assert property (@(posedge clk_i) disable iff (!rst_n)
        match_b |=> timer_flag_reg_o[2])
        else $error("compare b flag missed");
    a_irq_gate_all: assert property (@(posedge clk_i) disable iff (!rst_n)
        irq_o == (timer_flag_reg_o & timer_mask_reg_i))
        else $error("irq mask gating wrong");
    a_force_noflag_b: assert property (@(posedge clk_i) disable iff (!rst_n)
        (force_compare_strobe_b_i && !match_b && !flag_wr_i && !timer_flag_reg_o[2])
        |=> !timer_flag_reg_o[2])
        else $error("force set b flag");
    a_force_set_b: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!pwm && enable && force_compare_strobe_b_i && compare_output_mode_b_i == TCU_COM_SET)
        |=> compare_out_b_o)
        else $error("force did not set output b");
    a_direct_write: assert property (@(posedge clk_i) disable iff (!rst_n)
        (!pwm && enable && compare_a_wr_i) |=> (compare_value_a_o == $past(compare_wdata_i)))
        else $error("direct compare write lost");
    a_buffer_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
        (pwm && enable && compare_b_wr_i && !tick) |=> $stable(st.cmp_b))
        else $error("buffered write reached comparator");
    a_service_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
        (irq_serviced_i[0] && !set_flags[0]) |=> !timer_flag_reg_o[0])
        else $error("serviced flag not cleared");
    a_off_frozen: assert property (@(posedge clk_i) disable iff (!rst_n)
        power_reduce_bit_i |=> $stable(count_value_o))
        else $error("counter moved while powered down");
    a_ctc_wrap: assert property (@(posedge clk_i) disable iff (!rst_n)
        (seq == TCU_SEQ_CTC && tick && st.count == st.cmp_a && !(count_wr_i && enable))
        |=> count_value_o == TCU_BOTTOM)
        else $error("ctc did not clear on compare a");

    c_normal_wrap: cover property (@(posedge clk_i) disable iff (!rst_n)
        seq == TCU_SEQ_NORMAL && tick && at_max);
    c_ctc_clear: cover property (@(posedge clk_i) disable iff (!rst_n)
        seq == TCU_SEQ_CTC && match_a);
    c_fast_reload: cover property (@(posedge clk_i) disable iff (!rst_n)
        seq == TCU_SEQ_FAST && tick && at_top);
    c_force: cover property (@(posedge clk_i) disable iff (!rst_n)
        force_compare_strobe_b_i && !pwm);
    c_phase_bottom: cover property (@(posedge clk_i) disable iff (!rst_n)
        seq == TCU_SEQ_PHASE && tick && at_bottom);
endmodule // tcu_timer

// *** testbench/tcu_timer_tb.sv ***
module tcu_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tcu_pkg::*;

    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic power_reduce_bit_i = 1'b0;
    logic async_clock_select_i = 1'b0;
    logic crystal_pin_in_i = 1'b0;
    logic [2:0] clock_select_field_i = TCU_CS_STOP;
    logic [1:0] waveform_mode_low_i = 2'h0;
    logic waveform_mode_high_i = 1'b0;
    logic [1:0] compare_output_mode_a_i = TCU_COM_NONE;
    logic [1:0] compare_output_mode_b_i = TCU_COM_NONE;
    logic count_wr_i = 1'b0;
    logic [7:0] count_wdata_i = 8'h00;
    logic compare_a_wr_i = 1'b0;
    logic compare_b_wr_i = 1'b0;
    logic [7:0] compare_wdata_i = 8'h00;
    logic force_compare_strobe_a_i = 1'b0;
    logic force_compare_strobe_b_i = 1'b0;
    logic flag_wr_i = 1'b0;
    logic [2:0] flag_wdata_i = 3'h0;
    logic [2:0] timer_mask_reg_i = 3'h0;
    logic [2:0] irq_serviced_i = 3'h0;
    logic [7:0] count_value_o;
    logic [7:0] compare_value_a_o;
    logic [7:0] compare_value_b_o;
    logic [2:0] timer_flag_reg_o;
    logic [2:0] irq_o;
    logic compare_out_a_o;
    logic compare_out_b_o;
    logic crystal_pin_out_o;
    logic timer_tick_o;
    int miscompares = 0;
    int samples_checked = 0;
    logic [7:0] held;

    always #20 clk_i = ~clk_i;

    tcu_timer uut (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .power_reduce_bit_i(power_reduce_bit_i),
        .async_clock_select_i(async_clock_select_i),
        .crystal_pin_in_i(crystal_pin_in_i),
        .clock_select_field_i(clock_select_field_i),
        .waveform_mode_low_i(waveform_mode_low_i),
        .waveform_mode_high_i(waveform_mode_high_i),
        .compare_output_mode_a_i(compare_output_mode_a_i),
        .compare_output_mode_b_i(compare_output_mode_b_i),
        .count_wr_i(count_wr_i),
        .count_wdata_i(count_wdata_i),
        .compare_a_wr_i(compare_a_wr_i),
        .compare_b_wr_i(compare_b_wr_i),
        .compare_wdata_i(compare_wdata_i),
        .force_compare_strobe_a_i(force_compare_strobe_a_i),
        .force_compare_strobe_b_i(force_compare_strobe_b_i),
        .flag_wr_i(flag_wr_i),
        .flag_wdata_i(flag_wdata_i),
        .timer_mask_reg_i(timer_mask_reg_i),
        .irq_serviced_i(irq_serviced_i),
        .count_value_o(count_value_o),
        .compare_value_a_o(compare_value_a_o),
        .compare_value_b_o(compare_value_b_o),
        .timer_flag_reg_o(timer_flag_reg_o),
        .irq_o(irq_o),
        .compare_out_a_o(compare_out_a_o),
        .compare_out_b_o(compare_out_b_o),
        .crystal_pin_out_o(crystal_pin_out_o),
        .timer_tick_o(timer_tick_o)
    );

    // every drive lands 1 ns after the edge, so sampling never races the design
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        samples_checked++;
        if (seen !== expected) begin
            miscompares++;
            $display("FAIL %0t value %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic wr_count(input logic [7:0] v);
        count_wr_i = 1'b1;
        count_wdata_i = v;
        step(1);
        count_wr_i = 1'b0;
    endtask

    task automatic wr_cmp(input logic sel_b, input logic [7:0] v);
        compare_a_wr_i = ~sel_b;
        compare_b_wr_i = sel_b;
        compare_wdata_i = v;
        step(1);
        compare_a_wr_i = 1'b0;
        compare_b_wr_i = 1'b0;
    endtask

    task automatic wr_flags(input logic [2:0] v);
        flag_wr_i = 1'b1;
        flag_wdata_i = v;
        step(1);
        flag_wr_i = 1'b0;
    endtask

    task automatic force_a();
        force_compare_strobe_a_i = 1'b1;
        step(1);
        force_compare_strobe_a_i = 1'b0;
    endtask

    task automatic force_b();
        force_compare_strobe_b_i = 1'b1;
        step(1);
        force_compare_strobe_b_i = 1'b0;
    endtask

    // bounded poll; a miss shows up as one mismatch on the count
    task automatic wait_count(input logic [7:0] v);
        int n = 0;
        while (count_value_o !== v && n < 600) begin
            step(1);
            n++;
        end
        if (n == 600) check(count_value_o, v);
    endtask

    task automatic set_mode(input logic [2:0] m);
        waveform_mode_low_i = m[1:0];
        waveform_mode_high_i = m[2];
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        report_and_stop();
    end

    initial begin
        logic [2:0] modes [3] = '{TCU_WGM_NORMAL, TCU_WGM_CTC, TCU_WGM_FAST_A};
        logic [7:0] after_top [3] = '{8'h06, 8'h00, 8'h00};
        step(5);
        rstn_i = 1'b1;
        step(3);
        check(count_value_o, TCU_COUNT_RST);
        check(compare_value_a_o, TCU_CMP_RST);
        check(compare_value_b_o, TCU_CMP_RST);
        check({5'h0, timer_flag_reg_o}, 8'h00);
        power_reduce_bit_i = 1'b1;
        wr_count(8'h33);
        check(count_value_o, 8'h00);
        power_reduce_bit_i = 1'b0;
        wr_count(8'hfd);
        step(4);
        check(count_value_o, 8'hfd);
        timer_mask_reg_i = 3'h1;
        clock_select_field_i = 3'h1;
        step(0);
        check({7'h0, timer_tick_o}, 8'h01);
        wait_count(TCU_BOTTOM);
        clock_select_field_i = TCU_CS_STOP;
        check({5'h0, timer_flag_reg_o}, 8'h01);
        check({5'h0, irq_o}, 8'h01);
        wr_flags(3'h6);
        check({7'h0, timer_tick_o}, 8'h00);
        wr_flags(3'h0);
        check({5'h0, timer_flag_reg_o}, 8'h01);
        irq_serviced_i = 3'h1;
        step(1);
        irq_serviced_i = 3'h0;
        check({5'h0, timer_flag_reg_o}, 8'h00);
        compare_output_mode_a_i = TCU_COM_TOGGLE;
        wr_cmp(1'b0, 8'h20);
        check(compare_value_a_o, 8'h20);
        wr_count(8'h1e);
        clock_select_field_i = 3'h1;
        wait_count(8'h20);
        check({5'h0, timer_flag_reg_o}, 8'h00);
        step(1);
        clock_select_field_i = TCU_CS_STOP;
        check({5'h0, timer_flag_reg_o}, 8'h02);
        check({7'h0, compare_out_a_o}, 8'h01);
        check({5'h0, irq_o}, 8'h00);
        wr_flags(3'h2);
        check({5'h0, timer_flag_reg_o}, 8'h00);
        wr_cmp(1'b1, 8'h40);
        wr_count(8'h40);
        clock_select_field_i = 3'h1;
        step(1);
        wr_count(8'h80);
        check(count_value_o, 8'h80);
        clock_select_field_i = TCU_CS_STOP;
        check({7'h0, timer_flag_reg_o[2]}, 8'h00);
        held = count_value_o;
        compare_output_mode_b_i = TCU_COM_SET;
        force_b();
        check({7'h0, compare_out_b_o}, 8'h01);
        check({5'h0, timer_flag_reg_o}, 8'h00);
        check(count_value_o, held);
        compare_output_mode_b_i = TCU_COM_CLEAR;
        force_b();
        check({7'h0, compare_out_b_o}, 8'h00);
        force_a();
        check({7'h0, compare_out_a_o}, 8'h00);
        force_a();
        check({7'h0, compare_out_a_o}, 8'h01);
        check({5'h0, timer_flag_reg_o}, 8'h00);
        set_mode(TCU_WGM_FAST_FF);
        step(1);
        check({6'h0, compare_out_a_o, compare_out_b_o}, 8'h02);
        compare_output_mode_b_i = TCU_COM_SET;
        force_b();
        check({7'h0, compare_out_b_o}, 8'h00);
        // buffered value must not reach the comparator before TOP
        wr_cmp(1'b1, 8'h12);
        check(compare_value_b_o, 8'h12);
        wr_count(8'h10);
        wr_flags(3'h7);
        clock_select_field_i = 3'h1;
        wait_count(8'h14);
        check({7'h0, timer_flag_reg_o[2]}, 8'h00);
        wait_count(8'h42);
        check({7'h0, timer_flag_reg_o[2]}, 8'h01);
        check({7'h0, compare_out_b_o}, 8'h01);
        clock_select_field_i = TCU_CS_STOP;
        set_mode(TCU_WGM_CTC);
        wr_cmp(1'b0, 8'h05);
        for (int i = 0; i < 3; i++) begin
            set_mode(modes[i]);
            wr_count(8'h00);
            clock_select_field_i = 3'h1;
            wait_count(8'h05);
            step(1);
            clock_select_field_i = TCU_CS_STOP;
            check(count_value_o, after_top[i]);
        end
        // dual slope: up to compare a, back down, overflow at the bottom turn
        set_mode(TCU_WGM_PC_A);
        wr_count(8'h03);
        wr_flags(3'h7);
        clock_select_field_i = 3'h1;
        wait_count(8'h05);
        step(2);
        check(count_value_o, 8'h03);
        wait_count(TCU_BOTTOM);
        step(1);
        clock_select_field_i = TCU_CS_STOP;
        check(count_value_o, 8'h01);
        check({7'h0, timer_flag_reg_o[0]}, 8'h01);
        set_mode(TCU_WGM_NORMAL);
        wr_count(8'h00);
        async_clock_select_i = 1'b1;
        clock_select_field_i = 3'h1;
        step(4);
        check(count_value_o, 8'h00);
        repeat (3) begin
            crystal_pin_in_i = 1'b1;
            step(4);
            check({7'h0, crystal_pin_out_o}, 8'h00);
            crystal_pin_in_i = 1'b0;
            step(4);
        end
        step(4);
        check(count_value_o, 8'h03);
        report_and_stop();
    end
endmodule // tcu_timer_tb
